// ===== src/ghp_pkg.sv
// shared constants for the generic async host bus port
package ghp_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	localparam logic [16:0] WIN_MASK = 17'h1ffff;
	localparam logic [16:0] FB_TOP = 17'h13fff;
	localparam logic [16:0] REG_BASE = 17'h1ffe0;
	localparam int REG_COUNT = 32;
	localparam logic [2:0] BUS_SEL_GENERIC2 = 3'h7;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
	localparam int ARB_CYCLES = 4;
	localparam int LINK_DIV = 8;
	localparam logic [31:0] ADDR_REGION = 32'h0a000000;
	localparam logic [7:0] REGION_TOP = 8'h0a;
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_WDATA = 8'h04;
	localparam logic [7:0] APB_STAT = 8'h08;
	localparam logic [7:0] APB_RDATA = 8'h0c;
	localparam int CMD_GO = 31;
	localparam int CMD_WR = 30;
	localparam int CMD_BYTE = 29;
	localparam int CMD_BIGEND = 28;
	typedef enum logic [1:0] {
		GHP_IDLE = 2'b00,
		GHP_WAIT = 2'b01,
		GHP_DONE = 2'b10
	} ghp_dev_state_t;
	typedef enum logic [1:0] {
		GHP_H_IDLE = 2'b00,
		GHP_H_STROBE = 2'b01,
		GHP_H_END = 2'b10
	} ghp_host_state_t;
endpackage

// ===== src/ghp_link_if.sv
// interface joining the host end and the lcd port end
`timescale 1ns/1ps
`default_nettype none
interface ghp_link_if;
	logic host_bus_clock;
	logic lcd_block_select_n;
	logic rd_strobe_n;
	logic low_write_strobe_n;
	logic high_byte_strobe_n;
	logic bus_status_n;
	logic rd_wr_dir;
	logic [16:0] device_address_inputs;
	logic [15:0] host_data_out;
	logic host_data_oe;
	logic [15:0] dev_data_out;
	logic dev_data_oe;
	logic host_ready_line;
	logic host_ready_oe;
	wire [15:0] device_data_lines = host_data_oe ? host_data_out :
		(dev_data_oe ? dev_data_out : 16'h0000);
	wire wait_level = host_ready_oe ? host_ready_line : 1'b1;
	modport host (output host_bus_clock, lcd_block_select_n, rd_strobe_n,
		low_write_strobe_n, high_byte_strobe_n, bus_status_n, rd_wr_dir,
		device_address_inputs, host_data_out, host_data_oe,
		input device_data_lines, wait_level);
	modport dev (input host_bus_clock, lcd_block_select_n, rd_strobe_n,
		low_write_strobe_n, high_byte_strobe_n, bus_status_n, rd_wr_dir,
		device_address_inputs, device_data_lines,
		output dev_data_out, dev_data_oe, host_ready_line, host_ready_oe);
endinterface
`default_nettype wire

// ===== src/ghp_dev_port.sv
// lcd controller host port end: decode, byte lanes, wait states
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ghp_dev_port #(
	parameter int ARB_CYCLES = ghp_pkg::ARB_CYCLES
) (
	input wire logic mclk, // core clock
	input wire logic rst_n, // sync reset, active low
	ghp_link_if.dev link, // host bus pins
	input wire logic [2:0] bus_select_pins, // strap pins
	input wire logic endian_select_pin, // strap pin
	input wire logic refresh_busy, // display refresh holds memory
	output logic mode_generic2, // strap decode result
	output logic big_endian // latched byte order
);
	localparam int FB_WORDS = 40960;
	logic [15:0] fb_mem [0:FB_WORDS-1];
	logic [15:0] reg_mem [0:15];
	logic [2:0] clk_s_reg, cs_s_reg, rd_s_reg, we0_s_reg, we1_s_reg;
	logic [2:0] refresh_s_reg;
	logic rst_seen_reg;
	logic mode_reg, big_reg;
	ghp_pkg::ghp_dev_state_t state_reg;
	logic [3:0] arb_reg;
	logic [15:0] dout_reg;
	logic doe_reg, wait_reg, rdy_oe_reg;
	logic [16:0] addr_reg;
	logic [15:0] wdata_reg;

	////////////////////////////////////////////////////////////////////
	// two-flop synchronisers, the third stage is edge history only
	always_ff @(posedge mclk) begin
		clk_s_reg <= {clk_s_reg[1:0], link.host_bus_clock};
		cs_s_reg <= {cs_s_reg[1:0], link.lcd_block_select_n};
		rd_s_reg <= {rd_s_reg[1:0], link.rd_strobe_n};
		we0_s_reg <= {we0_s_reg[1:0], link.low_write_strobe_n};
		we1_s_reg <= {we1_s_reg[1:0], link.high_byte_strobe_n};
		refresh_s_reg <= {refresh_s_reg[1:0], refresh_busy};
	end
	// the direction pin is never looked at here; bus status only gates the strap decode
	wire bclk_rise = clk_s_reg[1] & ~clk_s_reg[2];
	wire sel = ~cs_s_reg[1];
	wire rd = ~rd_s_reg[1];
	wire wr = ~we0_s_reg[1];
	wire hi_en = ~we1_s_reg[1];
	wire [16:0] win_addr = link.device_address_inputs & ghp_pkg::WIN_MASK;
	wire is_fb = win_addr <= ghp_pkg::FB_TOP;
	wire is_reg = win_addr >= ghp_pkg::REG_BASE;
	wire [15:0] fb_idx = win_addr[16:1];
	wire [3:0] reg_idx = addr_reg[4:1];
	wire addr_lsb = addr_reg[0];
	wire arb_done = (arb_reg == 4'h0) & ~refresh_s_reg[1];

	////////////////////////////////////////////////////////////////////
	// straps are taken at the first clock after reset release
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rst_seen_reg <= 1'b0;
			mode_reg <= 1'b0;
			big_reg <= 1'b0;
		end else if (!rst_seen_reg) begin
			rst_seen_reg <= 1'b1;
			mode_reg <= (bus_select_pins == ghp_pkg::BUS_SEL_GENERIC2)
				& link.bus_status_n;
			big_reg <= endian_select_pin;
		end
	end
	assign mode_generic2 = mode_reg;
	assign big_endian = big_reg;

	////////////////////////////////////////////////////////////////////
	// access engine; wait only moves on bus clock rises
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= ghp_pkg::GHP_IDLE;
			wait_reg <= 1'b1;
			rdy_oe_reg <= 1'b0;
			doe_reg <= 1'b0;
			dout_reg <= 16'h0000;
			for (int k = 0; k < 16; k++) begin
				reg_mem[k] <= ghp_pkg::REG_RESET;
			end
			arb_reg <= 4'h0;
			addr_reg <= 17'h00000;
			wdata_reg <= 16'h0000;
		end else begin
			if (arb_reg != 4'h0) begin
				arb_reg <= arb_reg - 4'h1;
			end
			if (bclk_rise) begin
				case (state_reg)
				ghp_pkg::GHP_IDLE: begin
					if (sel && (rd || wr) && mode_reg) begin
						state_reg <= ghp_pkg::GHP_WAIT;
						wait_reg <= 1'b0;
						rdy_oe_reg <= 1'b1;
						addr_reg <= win_addr;
						wdata_reg <= link.device_data_lines;
						arb_reg <= 4'(ARB_CYCLES);
						doe_reg <= rd;
					end
				end
				ghp_pkg::GHP_WAIT: begin
					if (arb_done) begin
						state_reg <= ghp_pkg::GHP_DONE;
						wait_reg <= 1'b1;
						if (wr) begin
							if (addr_reg <= ghp_pkg::FB_TOP) begin
								if (hi_en || !addr_lsb)
									fb_mem[addr_reg[16:1]][7:0] <= big_reg ?
										wdata_reg[15:8] : wdata_reg[7:0];
								if (hi_en || addr_lsb)
									fb_mem[addr_reg[16:1]][15:8] <= big_reg ?
										wdata_reg[7:0] : wdata_reg[15:8];
							end else if (addr_reg >= ghp_pkg::REG_BASE) begin
								// registers keep lanes in bus order, no swap
								if (hi_en || !addr_lsb)
									reg_mem[reg_idx][7:0] <= wdata_reg[7:0];
								if (hi_en || addr_lsb)
									reg_mem[reg_idx][15:8] <= wdata_reg[15:8];
							end
						end else if (addr_reg <= ghp_pkg::FB_TOP) begin
							dout_reg <= big_reg ?
								{fb_mem[addr_reg[16:1]][7:0],
								fb_mem[addr_reg[16:1]][15:8]} :
								fb_mem[addr_reg[16:1]];
						end else if (addr_reg >= ghp_pkg::REG_BASE) begin
							dout_reg <= reg_mem[reg_idx];
						end else begin
							dout_reg <= ghp_pkg::UNMAPPED_DATA;
						end
					end
				end
				ghp_pkg::GHP_DONE: begin
					if (!sel || (!rd && !wr)) begin
						state_reg <= ghp_pkg::GHP_IDLE;
						doe_reg <= 1'b0;
						rdy_oe_reg <= 1'b0;
					end
				end
				default: state_reg <= ghp_pkg::GHP_IDLE;
				endcase
			end
		end
	end
	assign link.dev_data_out = dout_reg;
	assign link.dev_data_oe = doe_reg;
	assign link.host_ready_line = wait_reg;
	assign link.host_ready_oe = rdy_oe_reg;
	wire unused_ok = is_fb ^ is_reg ^ fb_idx[0];
endmodule // ghp_dev_port
`default_nettype wire

// ===== src/ghp_host_end.sv
// host end: apb command registers driving the lcd block bus cycle
`timescale 1ns/1ps
`default_nettype none
module ghp_host_end (
	input wire logic mclk, // core clock
	input wire logic rst_n, // sync reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	ghp_link_if.host link // lcd block pins
);
	logic [31:0] cmd_reg, wdata_reg, prdata_reg;
	logic [15:0] rdata_reg;
	logic busy_reg, done_reg, pready_reg, err_reg;
	logic [2:0] div_reg;
	logic bclk_reg, cs_reg, rd_reg, we_reg, hb_reg, oe_reg;
	logic [1:0] w_s_reg;
	ghp_pkg::ghp_host_state_t st_reg;

	logic w_seen_reg;
	logic [31:0] d_s_reg;
	// ready is raised one cycle after the access phase starts; writes
	// commit only at the edge where the master sees ready high
	wire acc = psel & penable & ~pready_reg;
	wire fin = psel & penable & pready_reg;
	wire cmd_wr = cmd_reg[ghp_pkg::CMD_WR];
	wire hit_cmd = paddr == ghp_pkg::APB_CMD;
	wire hit_wd = paddr == ghp_pkg::APB_WDATA;
	wire hit_st = paddr == ghp_pkg::APB_STAT;
	wire hit_rd = paddr == ghp_pkg::APB_RDATA;
	wire mapped = hit_cmd | hit_wd | hit_st | hit_rd;
	wire [31:0] rmux = hit_cmd ? cmd_reg : hit_wd ? wdata_reg :
		hit_st ? {30'h0, done_reg, busy_reg} :
		hit_rd ? {16'h0, rdata_reg} : 32'h0;
	wire bclk_fall = (div_reg == 3'(ghp_pkg::LINK_DIV - 1)) & bclk_reg;
	wire wait_low = ~w_s_reg[1];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pready_reg <= 1'b0;
			err_reg <= 1'b0;
			prdata_reg <= 32'h0;
			div_reg <= 3'h0;
			bclk_reg <= 1'b0;
			w_s_reg <= 2'b11;
			d_s_reg <= 32'h0;
		end else begin
			pready_reg <= acc;
			err_reg <= acc & ~mapped;
			if (acc && !pwrite)
				prdata_reg <= rmux;
			div_reg <= div_reg + 3'h1;
			if (div_reg == 3'(ghp_pkg::LINK_DIV / 2 - 1) ||
				div_reg == 3'(ghp_pkg::LINK_DIV - 1))
				bclk_reg <= ~bclk_reg;
			w_s_reg <= {w_s_reg[0], link.wait_level};
			// data follows the same two stages as wait, so they line up
			d_s_reg <= {d_s_reg[15:0], link.device_data_lines};
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus cycle; select, strobes and data enable move on bus clock falls so the device sees them
	// stable at its rising-edge sample
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmd_reg <= 32'h0;
			wdata_reg <= 32'h0;
			rdata_reg <= 16'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			st_reg <= ghp_pkg::GHP_H_IDLE;
			cs_reg <= 1'b1;
			rd_reg <= 1'b1;
			we_reg <= 1'b1;
			hb_reg <= 1'b1;
			oe_reg <= 1'b0;
			w_seen_reg <= 1'b0;
		end else begin
			if (fin && pwrite && hit_wd)
				wdata_reg <= pwdata;
			if (fin && pwrite && hit_cmd && !busy_reg) begin
				cmd_reg <= pwdata;
				busy_reg <= pwdata[ghp_pkg::CMD_GO];
				done_reg <= 1'b0;
			end
			// wait is high before the device answers, so only a high
			// level after a seen low ends the access
			if (wait_low)
				w_seen_reg <= 1'b1;
			if (bclk_fall) begin
				case (st_reg)
				ghp_pkg::GHP_H_IDLE: begin
					if (busy_reg) begin
						st_reg <= ghp_pkg::GHP_H_STROBE;
						cs_reg <= 1'b0;
						hb_reg <= cmd_reg[ghp_pkg::CMD_BYTE];
						rd_reg <= cmd_wr;
						we_reg <= ~cmd_wr;
						oe_reg <= cmd_wr;
						w_seen_reg <= 1'b0;
					end
				end
				ghp_pkg::GHP_H_STROBE: begin
					// strobes stand until the device releases wait
					if (w_seen_reg && !wait_low) begin
						st_reg <= ghp_pkg::GHP_H_END;
						cs_reg <= 1'b1;
						rd_reg <= 1'b1;
						we_reg <= 1'b1;
						hb_reg <= 1'b1;
						oe_reg <= 1'b0;
						rdata_reg <= d_s_reg[31:16];
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
				ghp_pkg::GHP_H_END: begin
					st_reg <= ghp_pkg::GHP_H_IDLE;
				end
				default: st_reg <= ghp_pkg::GHP_H_IDLE;
				endcase
			end
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = err_reg;
	assign link.host_bus_clock = bclk_reg;
	assign link.lcd_block_select_n = cs_reg;
	assign link.rd_strobe_n = rd_reg;
	assign link.low_write_strobe_n = we_reg;
	assign link.high_byte_strobe_n = hb_reg;
	assign link.bus_status_n = 1'b1;
	assign link.rd_wr_dir = 1'b1;
	assign link.device_address_inputs = cmd_reg[16:0];
	assign link.host_data_out = wdata_reg[15:0];
	assign link.host_data_oe = oe_reg;
endmodule // ghp_host_end
`default_nettype wire

// ===== verification/ghp_link_props.sv
// assertion checker for the lcd host link
`timescale 1ns/1ps
`default_nettype none
module ghp_link_props (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic lcd_block_select_n, // select
	input wire logic rd_strobe_n, // read
	input wire logic low_write_strobe_n, // write
	input wire logic bus_status_n, // strap
	input wire logic rd_wr_dir, // strap
	input wire logic [16:0] device_address_inputs, // address
	input wire logic host_data_oe, // host drive
	input wire logic dev_data_oe, // device drive
	input wire logic wait_level // wait
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////
	chk_wait_idle: assert property (
		lcd_block_select_n [*6] |-> wait_level) else $error("wait low idle");
	chk_read_drive: assert property (
		$rose(dev_data_oe) |-> !rd_strobe_n && !lcd_block_select_n)
		else $error("data driven outside read");
	chk_no_clash: assert property (
		!(dev_data_oe && host_data_oe)) else $error("data bus clash");
	chk_one_strobe: assert property (
		rd_strobe_n || low_write_strobe_n) else $error("two strobes");
	chk_addr_hold: assert property (
		!lcd_block_select_n && !$past(lcd_block_select_n) |->
		$stable(device_address_inputs)) else $error("address moved");
	chk_strap_high: assert property (
		bus_status_n && rd_wr_dir) else $error("strap not high");
	chk_wait_cause: assert property (
		$fell(wait_level) |-> !lcd_block_select_n &&
		!(rd_strobe_n && low_write_strobe_n)) else $error("stray wait");
	chk_data_valid: assert property (
		$rose(wait_level) && !rd_strobe_n |-> dev_data_oe)
		else $error("read ends without data");
	chk_wait_bound: assert property (
		$fell(wait_level) |-> ##[1:600] wait_level) else $error("wait hung");
	cover property ($rose(wait_level) && !rd_strobe_n);
	cover property ($rose(wait_level) && !low_write_strobe_n);
	cover property ($fell(wait_level));
endmodule // ghp_link_props
`default_nettype wire

// ===== verification/test_generic_async_host_bus_port.sv
// bench: apb host end drives the lcd port end over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_generic_async_host_bus_port;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, bt = 0;
	logic pready, pslverr, mode_generic2, big_endian, perr;
	logic refresh_busy = 0, endian_select_pin = 0;
	logic [2:0] bus_select_pins = 3'h7;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, t, rng = 32'h21, sd = 32'h21;
	logic [16:0] a;
	logic [15:0] q, shadow [logic [16:0]];
	int err_count = 0, samples_checked = 0, cyc = 0, i;
	ghp_link_if link();
	ghp_host_end ghp_host_end_inst (.mclk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
	ghp_dev_port ghp_dev_port_inst (.mclk, .rst_n, .link(link),
		.bus_select_pins, .endian_select_pin, .refresh_busy,
		.mode_generic2, .big_endian);
	ghp_link_props ghp_link_props_inst (.mclk, .rst_n,
		.lcd_block_select_n(link.lcd_block_select_n),
		.rd_strobe_n(link.rd_strobe_n),
		.low_write_strobe_n(link.low_write_strobe_n),
		.bus_status_n(link.bus_status_n), .rd_wr_dir(link.rd_wr_dir),
		.device_address_inputs(link.device_address_inputs),
		.host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
		.wait_level(link.wait_level));
	////////////////////////////////////////////////////////////
	always #4 mclk = ~mclk;
	// refresh steals the memory at random; the limit catches a hung wait
	always @(posedge mclk) begin
		sd <= xs(sd);
		refresh_busy <= sd[0] & sd[1];
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			results();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [15:0] exp_rd(input logic [16:0] ad);
		return shadow.exists(ad) ? shadow[ad] : ghp_pkg::REG_RESET;
	endfunction
	// a byte write only touches its own lane of the word
	function automatic void upd(input logic [16:0] ad, input logic b,
		input logic [15:0] d);
		logic [15:0] c;
		c = exp_rd(ad & 17'h1fffe);
		c[15:8] = (b && !ad[0]) ? c[15:8] : d[15:8];
		c[7:0] = (b && ad[0]) ? c[7:0] : d[7:0];
		shadow[ad & 17'h1fffe] = c;
	endfunction
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input logic w, b, input logic [16:0] ad,
		input logic [15:0] d, output logic [15:0] r);
		logic [31:0] x;
		apb(1'b1, ghp_pkg::APB_WDATA, {16'h0000, d}, x);
		apb(1'b1, ghp_pkg::APB_CMD, {1'b1, w, b, endian_select_pin, 11'h000, ad}, x);
		do apb(1'b0, ghp_pkg::APB_STAT, 32'h0, x); while (x[0] === 1'b1);
		apb(1'b0, ghp_pkg::APB_RDATA, 32'h0, x);
		r = x[15:0];
	endtask
	task automatic rst(input logic [2:0] s, input logic e);
		rst_n <= 1'b0;
		bus_select_pins <= s;
		endian_select_pin <= e;
		shadow.delete();
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(mode_generic2, s == 3'h7)
		`CHK(big_endian, e)
	endtask
	task automatic results();
		$display("compared %0d mismatched %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		rst(3'h6, 1'b0);
		apb(1'b0, 8'h10, 32'h0, t);
		`CHK(perr, 1'b1)
		for (int e = 0; e < 2; e++) begin
			rst(3'h7, e[0]);
			for (i = 0; i < 16; i++) begin
				a = ghp_pkg::REG_BASE + 17'(2 * i);
				op(1'b0, 1'b0, a, 16'h0000, q);
				`CHK(q, exp_rd(a))
			end
			// byte lanes only in little-endian order, where the lane is fixed
			for (i = 0; i < 24; i++) begin
				rng = xs(rng);
				a = rng[2] ? ghp_pkg::REG_BASE + 17'(rng[8:4]) : 17'(rng[29:16]);
				bt = rng[3] & rng[2] & !e[0];
				a[0] = a[0] & bt;
				rng = xs(rng);
				op(1'b1, bt, a, rng[15:0], q);
				upd(a, bt, rng[15:0]);
				a[0] = 1'b0;
				op(1'b0, 1'b0, a, 16'h0000, q);
				`CHK(q, exp_rd(a))
			end
			op(1'b0, 1'b0, 17'h14000, 16'h0000, q);
			`CHK(q, ghp_pkg::UNMAPPED_DATA)
		end
		results();
	end
endmodule // test_generic_async_host_bus_port
`default_nettype wire
